// file: scs_pkg.sv
/*
 Package for the clock-suspend block of a synchronous DRAM model:
 command encodings, state codes, reset values and the shared command struct.
 Assumes a single rising-edge system clock shared with the controller.
*/
package scs_pkg;

   // Command codes as {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_INHIBIT = 4'h8;
   localparam logic [3:0] CMD_NOP     = 4'h7;
   localparam logic [3:0] CMD_ACT     = 4'h3;
   localparam logic [3:0] CMD_READ    = 4'h5;
   localparam logic [3:0] CMD_WRITE   = 4'h4;
   localparam logic [3:0] CMD_PRE     = 4'h2;

   // Defaults and reset values
   localparam int         DATA_W_DEF  = 16;
   localparam int         BURST_DEF   = 4;
   localparam int         CL_DEF      = 2;
   localparam int         CNT_W       = 8;
   localparam logic [7:0] CNT_RST     = 8'h00;

   // Operating modes, one-hot
   typedef enum logic [3:0] {
      ST_IDLE    = 4'h1,
      ST_ACCESS  = 4'h2,
      ST_SUSPEND = 4'h4,
      ST_PDOWN   = 4'h8
   } scs_mode_t;

   // Command bundle from the controller
   typedef struct packed {
      logic [3:0] code;
      logic       gate;
   } scs_cmd_t;

endpackage

// file: scs_burst.sv
/*
 Burst counter for the clock-suspend block.
 Assumes the caller supplies a qualified internal clock-edge pulse.
*/
`timescale 1ns/1ns
module scs_burst
#(
   parameter int BURST = scs_pkg::BURST_DEF
)
(
   // Clock and reset
   input  wire logic                    clock,
   input  wire logic                    arst_n,
   // Control
   input  wire logic                    tick,
   input  wire logic                    start,
   // Status
   output logic                         busy,
   output logic [scs_pkg::CNT_W-1:0]    count
);

   // Refuse burst lengths the counter cannot reach
   if (BURST < 1 || BURST > 255)
   begin
      $error("scs_burst: BURST out of range");
   end

   typedef struct packed {
      logic                      busy;
      logic [scs_pkg::CNT_W-1:0] count;
   } scs_bst_t;

   scs_bst_t st;
   scs_bst_t next_st;

   // Next state: advance only on live internal edges
   always_comb
   begin
      next_st = st;
      if (tick)
      begin
         if (start)
         begin
            next_st.busy  = 1'b1;
            next_st.count = scs_pkg::CNT_RST;
         end
         else if (st.busy)
         begin
            if (st.count == 8'(BURST - 1))
               next_st.busy = 1'b0;
            else
               next_st.count = st.count + 8'h01;
         end
      end
   end

   // State register
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         st <= '{busy: 1'b0, count: scs_pkg::CNT_RST};
      else
         st <= next_st;
   end

   assign busy  = st.busy;
   assign count = st.count;

endmodule

// file: scs_core.sv
/*
 Clock-suspend core of a synchronous DRAM: gates the internal clock
 edge from the registered clock-gate input and freezes the access.
 Assumes the controller drives commands and data on the same edge.
*/
`timescale 1ns/1ns
module scs_core
#(
   parameter int DATA_W = scs_pkg::DATA_W_DEF,
   parameter int BURST  = scs_pkg::BURST_DEF,
   parameter int CL     = scs_pkg::CL_DEF
)
(
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 arst_n,
   // Command and write data from controller
   input  wire scs_pkg::scs_cmd_t    cmd,
   input  wire logic [DATA_W-1:0]    wr_data,
   // Data lines
   output logic [DATA_W-1:0]         dq_out,
   output logic                      dq_oe,
   // Status
   output scs_pkg::scs_mode_t        mode,
   output logic                      int_edge,
   output logic [scs_pkg::CNT_W-1:0] burst_pos,
   output logic [DATA_W-1:0]         last_wr
);

   // Refuse widths and latencies the datapath cannot hold
   if (DATA_W < 1 || CL < 1 || CL > 7)
   begin
      $error("scs_core: parameter out of range");
   end

   ////////////////////////////////////////////////////////////////////
   // Decode helpers
   function automatic logic is_idle_cmd(input logic [3:0] c);
      is_idle_cmd = (c == scs_pkg::CMD_NOP) || c[3];
   endfunction

   typedef struct packed {
      scs_pkg::scs_mode_t mode;
      logic               live;     // internal edge enabled this cycle
      logic               is_read;
      logic [2:0]         lat;
      logic [DATA_W-1:0]  dq_out;
      logic               dq_oe;
      logic [DATA_W-1:0]  data_reg;
      logic [DATA_W-1:0]  last_wr;
      logic [scs_pkg::CNT_W-1:0] pos;
   } scs_core_t;

   scs_core_t st;
   scs_core_t next_st;

   logic                      b_busy;
   logic [scs_pkg::CNT_W-1:0] b_cnt;
   logic                      rw_cmd;
   logic                      start;
   logic                      access;
   logic                      last_word;

   assign rw_cmd = (cmd.code == scs_pkg::CMD_READ) || (cmd.code == scs_pkg::CMD_WRITE);
   assign start  = st.live && rw_cmd && st.mode != scs_pkg::ST_PDOWN;
   assign access = b_busy || st.lat != 3'h0;
   // Closing edge of a burst, after the final word, takes no data
   assign last_word = b_busy && b_cnt == 8'(BURST - 1);

   ////////////////////////////////////////////////////////////////////
   // Burst counter, advanced only by live internal edges
   // counter gated
   scs_burst #(.BURST(BURST)) u_burst
   (
      .clock  (clock),
      .arst_n (arst_n),
      .tick   (st.live),
      .start  (start),
      .busy   (b_busy),
      .count  (b_cnt)
   );

   ////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      next_st = st;
      next_st.live = cmd.gate;
      case (st.mode)
         scs_pkg::ST_IDLE, scs_pkg::ST_ACCESS:
         begin
            if (!cmd.gate && (access || start))
               next_st.mode = scs_pkg::ST_SUSPEND;
            else if (!cmd.gate && is_idle_cmd(cmd.code))
               next_st.mode = scs_pkg::ST_PDOWN;
            else
               next_st.mode = (access || start) ? scs_pkg::ST_ACCESS : scs_pkg::ST_IDLE;
         end
         scs_pkg::ST_SUSPEND:
         begin
            if (cmd.gate)
               next_st.mode = scs_pkg::ST_ACCESS;
         end
         scs_pkg::ST_PDOWN:
         begin
            if (cmd.gate && is_idle_cmd(cmd.code))
               next_st.mode = scs_pkg::ST_IDLE;
         end
         default:
            next_st.mode = scs_pkg::ST_IDLE;
      endcase
      // all datapath state frozen without a live edge
      if (st.live && st.mode != scs_pkg::ST_PDOWN)
      begin
         if (start)
         begin
            next_st.is_read = (cmd.code == scs_pkg::CMD_READ);
            next_st.lat     = (cmd.code == scs_pkg::CMD_READ) ? 3'(CL) : 3'h0;
         end
         else if (st.lat != 3'h0)
            next_st.lat = st.lat - 3'h1;
         // write data taken only on live edges
         if ((start && cmd.code == scs_pkg::CMD_WRITE) || (b_busy && !st.is_read && !last_word))
         begin
            next_st.data_reg = wr_data;
            next_st.last_wr  = wr_data;
         end
         next_st.dq_oe  = st.is_read && (b_busy || st.lat != 3'h0);
         next_st.dq_out = st.data_reg + DATA_W'(b_cnt);
         next_st.pos    = b_cnt;
      end
   end

   // State register
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st      <= '0;
         st.mode <= scs_pkg::ST_IDLE;
         st.live <= 1'b1;
      end
      else
         st <= next_st;
   end

   assign mode      = st.mode;
   assign int_edge  = st.live;
   assign dq_out    = st.dq_out;
   assign dq_oe     = st.dq_oe;
   assign burst_pos = st.pos;
   assign last_wr   = st.last_wr;

   ////////////////////////////////////////////////////////////////////
   // Checks

   chk_skip_edge: assert property (@(posedge clock) disable iff (!arst_n)
      !cmd.gate |=> !int_edge)
      else $error("edge not skipped after low gate");

   chk_resume_edge: assert property (@(posedge clock) disable iff (!arst_n)
      cmd.gate |=> int_edge)
      else $error("edge not resumed after high gate");

   chk_dq_hold: assert property (@(posedge clock) disable iff (!arst_n)
      !int_edge |=> $stable(dq_out) && $stable(dq_oe))
      else $error("data lines changed while suspended");

   chk_burst_hold: assert property (@(posedge clock) disable iff (!arst_n)
      !int_edge |=> $stable(b_cnt) && $stable(burst_pos))
      else $error("burst advanced while suspended");

   chk_ignore_wr: assert property (@(posedge clock) disable iff (!arst_n)
      !int_edge |=> $stable(last_wr))
      else $error("write data taken on skipped edge");

   chk_frozen_take: assert property (@(posedge clock) disable iff (!arst_n)
      !int_edge |=> $stable(b_busy) && $stable(st.is_read))
      else $error("command taken on skipped edge");

   chk_enter_susp: assert property (@(posedge clock) disable iff (!arst_n)
      (mode == scs_pkg::ST_ACCESS && b_busy && !cmd.gate) |=> mode == scs_pkg::ST_SUSPEND)
      else $error("suspend not entered");

   chk_susp_hold: assert property (@(posedge clock) disable iff (!arst_n)
      (mode == scs_pkg::ST_SUSPEND && !cmd.gate) |=> mode == scs_pkg::ST_SUSPEND)
      else $error("suspend left while gate low");

   chk_susp_exit: assert property (@(posedge clock) disable iff (!arst_n)
      (mode == scs_pkg::ST_SUSPEND && cmd.gate) |=> mode == scs_pkg::ST_ACCESS)
      else $error("suspend not left on high gate");

   chk_enter_pdown: assert property (@(posedge clock) disable iff (!arst_n)
      (mode == scs_pkg::ST_IDLE && !access && !cmd.gate && cmd.code == scs_pkg::CMD_NOP)
      |=> mode == scs_pkg::ST_PDOWN)
      else $error("power-down not entered");

   chk_pdown_idle: assert property (@(posedge clock) disable iff (!arst_n)
      mode == scs_pkg::ST_PDOWN |-> !b_busy && !dq_oe)
      else $error("access active in power-down");

   chk_freeze_lat: assert property (@(posedge clock) disable iff (!arst_n)
      !int_edge |=> $stable(st.lat) && $stable(st.data_reg))
      else $error("internal state moved while suspended");

endmodule

// file: scs_ctrl_model.sv
/*
 Controller model facing the clock-suspend core: drives command,
 clock gate and write data. Assumes the bench calls issue once a cycle.
*/
`timescale 1ns/1ns
module scs_ctrl_model
(
   // Clock
   input  wire logic               clock,
   // Command side
   output scs_pkg::scs_cmd_t       cmd,
   output logic [15:0]             wr_data
);
   int stalls;

   ////////////////////////////////////////////////////////////////////
   // Idle bus at time zero
   initial
   begin
      cmd = '{code: scs_pkg::CMD_NOP, gate: 1'b1};
      wr_data = 16'h0000;
      stalls = 0;
   end

   // Gate high to resume, skipped edges stretch tracking
   task automatic issue(input logic [3:0] c, input logic g, input logic [15:0] d);
      @(posedge clock);
      if (!cmd.gate)
         stalls++;
      cmd <= '{code: c, gate: g};
      wr_data <= d;
   endtask
endmodule

// file: tb_sdram_clock_suspend.sv
/*
 Bench for the clock-suspend core: write, read and power-down cases.
 Assumes commands go out through the controller model one per cycle.
*/
`timescale 1ns/1ns
module tb_sdram_clock_suspend;
   logic                      clock = 1'b0;
   logic                      arst_n = 1'b0;
   scs_pkg::scs_cmd_t         cmd;
   logic [15:0]               wr_data, dq_out, last_wr, held;
   logic                      dq_oe, int_edge;
   scs_pkg::scs_mode_t        mode;
   logic [7:0]                burst_pos, bp;
   int                        n_fail = 0, checks = 0, cyc = 0;

   scs_core scs_core_i (.clock(clock), .arst_n(arst_n), .cmd(cmd), .wr_data(wr_data),
      .dq_out(dq_out), .dq_oe(dq_oe), .mode(mode), .int_edge(int_edge),
      .burst_pos(burst_pos), .last_wr(last_wr));
   scs_ctrl_model scs_ctrl_model_i (.clock(clock), .cmd(cmd), .wr_data(wr_data));

   ////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   always #25 clock = ~clock;
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_fail++;
         end_sim();
      end
   end

   task automatic cmp_val(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic cmp_mode(input scs_pkg::scs_mode_t e);
      checks++;
      if (mode !== e)
      begin
         n_fail++;
         $display("CHECK FAILED mode expected %h seen %h", e, mode);
      end
   endtask

   task automatic go(input logic [3:0] c, input logic g, input logic [15:0] d);
      scs_ctrl_model_i.issue(c, g, d);
      #1;
   endtask

   // Write burst frozen by gate low, new data ignored
   task automatic write_case();
      go(scs_pkg::CMD_WRITE, 1'b1, 16'hA5A5);
      go(scs_pkg::CMD_NOP, 1'b0, 16'hA5A5);
      go(scs_pkg::CMD_WRITE, 1'b0, 16'h5A5A);
      bp = burst_pos;
      go(scs_pkg::CMD_WRITE, 1'b0, 16'h5A5A);
      cmp_mode(scs_pkg::ST_SUSPEND);
      cmp_val("int_edge", 16'h0000, {15'h0000, int_edge});
      cmp_val("last_wr", 16'hA5A5, last_wr);
      cmp_val("burst_pos", {8'h00, bp}, {8'h00, burst_pos});
      go(scs_pkg::CMD_NOP, 1'b1, 16'hA5A5);
      cmp_val("frozen", {8'h00, bp}, {8'h00, burst_pos});
      go(scs_pkg::CMD_NOP, 1'b1, 16'hA5A5);
      go(scs_pkg::CMD_NOP, 1'b1, 16'hA5A5);
      cmp_val("resume", 16'h0001, {15'h0000, int_edge});
      cmp_val("last_wr", 16'hA5A5, last_wr);
      cmp_val("stalls", 16'h0003, 16'(scs_ctrl_model_i.stalls));
      repeat (2) go(scs_pkg::CMD_NOP, 1'b1, 16'h0000);
      cmp_mode(scs_pkg::ST_ACCESS);
      repeat (6) go(scs_pkg::CMD_NOP, 1'b1, 16'h0000);
      cmp_mode(scs_pkg::ST_IDLE);
      cmp_val("last_wr", 16'hA5A5, last_wr);
   endtask

   // Read data held on the lines while suspended
   task automatic read_case();
      int n;
      go(scs_pkg::CMD_READ, 1'b1, 16'h0000);
      n = 0;
      while (dq_oe !== 1'b1 && n < 10)
      begin
         go(scs_pkg::CMD_NOP, 1'b1, 16'h0000);
         n++;
      end
      go(scs_pkg::CMD_NOP, 1'b0, 16'h0000);
      go(scs_pkg::CMD_NOP, 1'b0, 16'h0000);
      held = dq_out;
      repeat (3) go(scs_pkg::CMD_READ, 1'b0, 16'h0000);
      cmp_val("dq_oe", 16'h0001, {15'h0000, dq_oe});
      cmp_val("dq_out", held, dq_out);
      cmp_val("dq_base", 16'hA5A7, held);
      repeat (10) go(scs_pkg::CMD_NOP, 1'b1, 16'h0000);
   endtask

   // Gate low with idle bus gives power-down, not suspend
   task automatic pdown_case();
      go(scs_pkg::CMD_NOP, 1'b0, 16'h0000);
      go(scs_pkg::CMD_NOP, 1'b0, 16'h0000);
      cmp_mode(scs_pkg::ST_PDOWN);
      go(scs_pkg::CMD_NOP, 1'b1, 16'h0000);
      go(scs_pkg::CMD_NOP, 1'b1, 16'h0000);
      cmp_mode(scs_pkg::ST_IDLE);
   endtask

   task automatic end_sim();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (6) @(posedge clock);
      arst_n <= 1'b1;
      repeat (2) go(scs_pkg::CMD_NOP, 1'b1, 16'h0000);
      write_case();
      read_case();
      pdown_case();
      end_sim();
   end
endmodule
